//--- hdl/txs_chip_seq.sv
// Chip position counter for one bit time of the spreading code
`default_nettype none

module txs_chip_seq
   import txs_pkg::*;
#(
   parameter int unsigned CODE_W = CHIPS_FULL     // Chips in the whole code
)
(
   input  wire logic                      ref_clk,     // System clock
   input  wire logic                      nrst,        // Asynchronous reset, active low
   input  wire logic                      run,         // Transmitter enabled
   input  wire txs_code_mode_type         mode,        // Code split mode
   output logic [$clog2(CODE_W)-1:0]      chip_idx_a,  // Code bit for channel A
   output logic [$clog2(CODE_W)-1:0]      chip_idx_b,  // Code bit for channel B
   output logic                           sym_end      // Last chip of a bit time
);

   localparam int unsigned CW = $clog2(CODE_W);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [CW-1:0] last;

   always_comb
   begin
      last = (mode == CM_FULL64) ? CW'(CODE_W - 1) : CW'(CODE_W / 2 - 1);
      // Compare with >= so a mode change mid-bit cannot strand the counter
      sym_end = run & (cnt_r >= last);
      if (!run || sym_end)
      begin
         cnt_nxt = '0;
      end
      else
      begin
         cnt_nxt = cnt_r + 1'b1;
      end
      chip_idx_a = (mode == CM_HIGH32) ? cnt_r + CW'(CODE_W / 2) : cnt_r;
      chip_idx_b = cnt_r + CW'(CODE_W / 2);
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule : txs_chip_seq

`default_nettype wire

//--- hdl/txs_flag.sv
// Sticky status flag where a set in the clearing cycle wins
`default_nettype none

module txs_flag (
   input  wire logic ref_clk,   // System clock
   input  wire logic nrst,      // Asynchronous reset, active low
   input  wire logic set,       // Event pulse
   input  wire logic clr,       // Clear pulse
   output logic      flag_r     // Sticky flag
);

   logic flag_nxt;

   always_comb
   begin
      flag_nxt = set | (flag_r & ~clr);
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         flag_r <= 1'b0;
      end
      else
      begin
         flag_r <= flag_nxt;
      end
   end

endmodule : txs_flag

`default_nettype wire

//--- hdl/txs_tx_serializer.sv
// Transmit serializer with status flags, spreading code and APB registers
`default_nettype none

// Summary of operation
// - Underflow flag when next bit lacks data
// - Underflow and done only after one bit
// - Overflow flag on write over held byte
// - Done flag when byte ends, nothing waiting
// - Empty flag when held byte enters shifter
// - Writing the data register clears empty
// - Status read clears underflow, overflow, done
// - Flags set regardless of interrupt enables
// - Transmit flags read zero while disabled
// - Status register read-only, bits 7:4 reserved
// - Data sent least significant bit first
// - Valid mask qualifies each data bit
// - 64-bit code in eight bytes, reset value
// - Code used whole or as halves
// - Chips emitted upward from bit 0, or from bit 32 in high mode and on channel B
// - Per-flag enables gate the interrupt
// - Invalid bits send preamble until mask drains
module txs_tx_serializer
   import txs_pkg::*;
(
   input  wire logic        ref_clk,        // System clock, 10 MHz
   input  wire logic        nrst,           // Asynchronous reset, active low
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB access phase
   input  wire logic        pwrite,         // APB direction
   input  wire logic [7:0]  paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   input  wire logic [3:0]  pstrb,          // APB byte strobes
   output logic      [31:0] prdata,         // APB read data
   output logic             pready,         // APB ready
   output logic             pslverr,        // APB error on unmapped index
   output logic             tx_chip_a,      // Channel A chip
   output logic             tx_chip_b,      // Channel B chip, dual mode only
   output logic             tx_chip_valid,  // Chips carry a byte
   output logic             tx_dual,        // Both channels in use
   output logic             irq             // Interrupt, active high level
);

   logic [31:0]            prdata_r, prdata_nxt;
   logic                   pready_r, pready_nxt;
   logic                   pslverr_r, pslverr_nxt;
   logic [7:0]             ctrl_r, ctrl_nxt;
   logic [7:0]             irq_en_r, irq_en_nxt;
   logic [7:0]             byte_r, byte_nxt;
   logic [7:0]             qual_r, qual_nxt;
   logic [1:0]             mode_r, mode_nxt;
   logic [63:0]            code_r, code_nxt;
   logic [FLG_N-1:0]       seen_r, seen_nxt;
   txs_tx_state_type       st_r, st_nxt;
   logic [7:0]             sh_data_r, sh_data_nxt;
   logic [7:0]             sh_valid_r, sh_valid_nxt;
   logic                   hold_full_r, hold_full_nxt;
   logic                   any_r, any_nxt;
   logic                   chip_a_r, chip_a_nxt;
   logic                   chip_b_r, chip_b_nxt;
   logic                   chip_valid_r, chip_valid_nxt;
   logic                   dual_r, dual_nxt;
   logic                   irq_r, irq_nxt;
   logic [FLG_N-1:0]       flag_r, flag_set, flag_clr, flag_vis;
   logic [5:0]             idx;
   logic                   acc_first, acc_done, wr, rd_stat, wr_byte, tx_en;
   logic                   load_go, done_ev, under_ev, over_ev, sym_end, bit_a, bit_b;
   logic [31:0]            rd_val;
   logic [7:0]             sh_data_s, sh_valid_s;
   logic [5:0]             idx_a, idx_b;
   txs_code_mode_type      mode;

   function automatic logic is_mapped(input logic [5:0] i);
      is_mapped = (i == IDX_CTRL) || (i == IDX_IRQ_EN) || (i == IDX_STAT) ||
                  (i == IDX_BYTE) || (i == IDX_QUAL) || (i == IDX_MODE) ||
                  ((i >= IDX_CODE0) && (i <= IDX_CODE_LAST));
   endfunction : is_mapped

   // A zero bit sends the inverted code, a one bit the code itself
   function automatic logic chip_of(input logic code_bit, input logic data_bit);
      chip_of = code_bit ^ ~data_bit;
   endfunction : chip_of

   assign mode = txs_code_mode_type'(mode_r);
   assign tx_en = ctrl_r[CTRL_TX_EN];

   // Bus slave: one wait state, so read data is captured before any clear-on-read
   always_comb
   begin
      idx = paddr[7:2];
      acc_first = psel & penable & ~pready_r;
      acc_done = psel & penable & pready_r;
      wr = acc_done & pwrite & pstrb[0] & is_mapped(idx);
      wr_byte = wr & (idx == IDX_BYTE);
      rd_stat = acc_done & ~pwrite & (idx == IDX_STAT);
      flag_vis = tx_en ? flag_r : '0;
      rd_val = 32'h0000_0000;
      case (idx)
         IDX_CTRL:   rd_val[7:0] = ctrl_r;
         IDX_IRQ_EN: rd_val[7:0] = {4'h0, irq_en_r[3:0]};
         IDX_STAT:   rd_val[7:0] = {4'h0, flag_vis};
         IDX_BYTE:   rd_val[7:0] = byte_r;
         IDX_QUAL:   rd_val[7:0] = qual_r;
         IDX_MODE:   rd_val[1:0] = mode_r;
         default:
         begin
            if ((idx >= IDX_CODE0) && (idx <= IDX_CODE_LAST))
            begin
               rd_val[7:0] = code_r[8 * (idx - IDX_CODE0) +: 8];
            end
         end
      endcase
      pready_nxt = acc_first;
      prdata_nxt = acc_first ? rd_val : prdata_r;
      pslverr_nxt = acc_first & ~is_mapped(idx);
      seen_nxt = seen_r;
      if (acc_first && !pwrite && (idx == IDX_STAT))
      begin
         seen_nxt = flag_vis;
      end
      ctrl_nxt = ctrl_r;
      irq_en_nxt = irq_en_r;
      byte_nxt = byte_r;
      qual_nxt = qual_r;
      mode_nxt = mode_r;
      code_nxt = code_r;
      if (wr)
      begin
         case (idx)
            IDX_CTRL:   ctrl_nxt = pwdata[7:0] & CTRL_MASK;
            IDX_IRQ_EN: irq_en_nxt = {4'h0, pwdata[3:0]};
            IDX_BYTE:   byte_nxt = pwdata[7:0];
            IDX_QUAL:   qual_nxt = pwdata[7:0];
            IDX_MODE:   mode_nxt = pwdata[1:0];
            default:
            begin
               if ((idx >= IDX_CODE0) && (idx <= IDX_CODE_LAST))
               begin
                  code_nxt[8 * (idx - IDX_CODE0) +: 8] = pwdata[7:0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         seen_r <= '0;
         ctrl_r <= CTRL_RST;
         irq_en_r <= IRQ_EN_RST;
         byte_r <= BYTE_RST;
         qual_r <= QUAL_RST;
         mode_r <= MODE_RST;
         code_r <= CODE_RST;
      end
      else
      begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         seen_r <= seen_nxt;
         ctrl_r <= ctrl_nxt;
         irq_en_r <= irq_en_nxt;
         byte_r <= byte_nxt;
         qual_r <= qual_nxt;
         mode_r <= mode_nxt;
         code_r <= code_nxt;
      end
   end

   txs_chip_seq #(
      .CODE_W     (CHIPS_FULL)
   ) u_chip_seq (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .run        (tx_en),
      .mode       (mode),
      .chip_idx_a (idx_a),
      .chip_idx_b (idx_b),
      .sym_end    (sym_end)
   );

   // Transmitter; loading waits a bit time if the host writes in that cycle
   always_comb
   begin
      st_nxt = st_r;
      sh_data_nxt = sh_data_r;
      sh_valid_nxt = sh_valid_r;
      any_nxt = any_r;
      load_go = 1'b0;
      done_ev = 1'b0;
      under_ev = 1'b0;
      over_ev = tx_en & wr_byte & hold_full_r;
      if (mode == CM_DUAL32)
      begin
         sh_data_s = {2'b00, sh_data_r[7:2]};
         sh_valid_s = {2'b00, sh_valid_r[7:2]};
      end
      else
      begin
         sh_data_s = {1'b0, sh_data_r[7:1]};
         sh_valid_s = {1'b0, sh_valid_r[7:1]};
      end
      case (st_r)
         TX_OFF:
         begin
            any_nxt = 1'b0;
            if (tx_en)
            begin
               st_nxt = TX_IDLE;
            end
         end
         TX_IDLE:
         begin
            if (!tx_en)
            begin
               st_nxt = TX_OFF;
            end
            else if (sym_end)
            begin
               if (hold_full_r && !wr_byte)
               begin
                  load_go = 1'b1;
                  st_nxt = TX_SHIFT;
               end
               else
               begin
                  under_ev = any_r;
               end
            end
         end
         TX_SHIFT:
         begin
            if (!tx_en)
            begin
               st_nxt = TX_OFF;
               sh_valid_nxt = '0;
            end
            else if (sym_end)
            begin
               any_nxt = 1'b1;
               sh_data_nxt = sh_data_s;
               sh_valid_nxt = sh_valid_s;
               if (sh_valid_s == 8'h00)
               begin
                  if (hold_full_r && !wr_byte)
                  begin
                     load_go = 1'b1;
                  end
                  else
                  begin
                     done_ev = 1'b1;
                     st_nxt = TX_IDLE;
                  end
               end
            end
         end
         default:
         begin
            st_nxt = TX_OFF;
         end
      endcase
      if (load_go)
      begin
         sh_data_nxt = byte_r;
         sh_valid_nxt = qual_r;
      end
      hold_full_nxt = wr_byte | (hold_full_r & ~load_go);
      bit_a = sh_valid_r[0] ? sh_data_r[0] : PREAMBLE_BIT;
      bit_b = sh_valid_r[1] ? sh_data_r[1] : PREAMBLE_BIT;
      chip_a_nxt = chip_of(code_r[idx_a], bit_a);
      chip_b_nxt = (mode == CM_DUAL32) & chip_of(code_r[idx_b], bit_b);
      // Follows the state one cycle late so it frames the registered chips exactly
      chip_valid_nxt = (st_r == TX_SHIFT) && tx_en;
      dual_nxt = (mode == CM_DUAL32);
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= TX_OFF;
         sh_data_r <= 8'h00;
         sh_valid_r <= 8'h00;
         hold_full_r <= 1'b0;
         any_r <= 1'b0;
         chip_a_r <= 1'b0;
         chip_b_r <= 1'b0;
         chip_valid_r <= 1'b0;
         dual_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         sh_data_r <= sh_data_nxt;
         sh_valid_r <= sh_valid_nxt;
         hold_full_r <= hold_full_nxt;
         any_r <= any_nxt;
         chip_a_r <= chip_a_nxt;
         chip_b_r <= chip_b_nxt;
         chip_valid_r <= chip_valid_nxt;
         dual_r <= dual_nxt;
      end
   end

   // Flags and interrupt; only bits that a read actually returned are cleared
   always_comb
   begin
      flag_set = '0;
      flag_set[FLG_EMPTY] = load_go;
      flag_set[FLG_DONE] = done_ev;
      flag_set[FLG_OVER] = over_ev;
      flag_set[FLG_UNDER] = under_ev;
      flag_clr = {FLG_N{~tx_en}} | ({FLG_N{rd_stat}} & seen_r & 4'b1110);
      flag_clr[FLG_EMPTY] = ~tx_en | wr_byte;
      irq_nxt = tx_en & (|(flag_r & irq_en_r[3:0]));
   end

   for (genvar g = 0; g < FLG_N; g++)
   begin : g_flag
      txs_flag u_flag (
         .ref_clk (ref_clk),
         .nrst    (nrst),
         .set     (flag_set[g]),
         .clr     (flag_clr[g]),
         .flag_r  (flag_r[g])
      );
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= irq_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign tx_chip_a = chip_a_r;
   assign tx_chip_b = chip_b_r;
   assign tx_chip_valid = chip_valid_r;
   assign tx_dual = dual_r;
   assign irq = irq_r;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   a_done_after_bit: assert property ($rose(flag_r[FLG_DONE]) |-> $past(any_nxt))
      else $error("done flag raised before any bit was sent");
   a_under_after_bit: assert property ($rose(flag_r[FLG_UNDER]) |-> $past(any_r))
      else $error("underflow flag raised before any bit was sent");
   a_under_idle_tick: assert property ((st_r == TX_IDLE && tx_en && sym_end && any_r && !hold_full_r) |=> flag_r[FLG_UNDER])
      else $error("underflow not flagged on empty holding register");
   a_overflow_write: assert property ((tx_en && wr_byte && hold_full_r) |=> flag_r[FLG_OVER])
      else $error("overflow not flagged on write over held byte");
   a_empty_on_load: assert property ((load_go && tx_en) |=> flag_r[FLG_EMPTY] && sh_data_r == $past(byte_r))
      else $error("load did not set empty or move the byte");
   a_empty_clr_write: assert property ((wr_byte && !load_go) |=> !flag_r[FLG_EMPTY])
      else $error("empty flag survived a data write");
   a_read_clears: assert property ((rd_stat && seen_r[FLG_DONE] && !done_ev) |=> !flag_r[FLG_DONE])
      else $error("status read did not clear done flag");
   a_enable_ignored: assert property ((load_go && tx_en && !irq_en_r[FLG_EMPTY]) |=> flag_r[FLG_EMPTY])
      else $error("flag set depended on its interrupt enable");
   a_stat_gated: assert property ((acc_first && !pwrite && idx == IDX_STAT && !tx_en) |=> prdata_r == 32'h0000_0000)
      else $error("status read nonzero while transmit disabled");
   a_lsb_first: assert property ((st_r == TX_SHIFT && tx_en && sym_end && mode == CM_FULL64 && sh_valid_s != 8'h00) |=> sh_data_r[6:0] == $past(sh_data_r[7:1]))
      else $error("shifter did not move toward bit 0");
   a_chip_upward: assert property ((tx_en && !sym_end && mode == CM_FULL64) ##1 (tx_en && mode == CM_FULL64) |-> idx_a == $past(idx_a) + 6'h01)
      else $error("chip index did not advance by one");
   a_irq_follows: assert property ((tx_en && |(flag_r & irq_en_r[3:0])) |=> irq_r)
      else $error("interrupt low with an enabled flag pending");
   a_irq_quiet: assert property ((!(|(flag_r & irq_en_r[3:0]))) |=> !irq_r)
      else $error("interrupt high with no enabled flag pending");

endmodule : txs_tx_serializer

`default_nettype wire

//--- shared/txs_pkg.sv
// Register map, field layout, reset values and counts of the transmit serializer
`default_nettype none

package txs_pkg;

   // Register indices; byte address on the bus is four times the index
   localparam logic [5:0]  IDX_CTRL      = 6'h03;
   localparam logic [5:0]  IDX_IRQ_EN    = 6'h0d;
   localparam logic [5:0]  IDX_STAT      = 6'h0e;
   localparam logic [5:0]  IDX_BYTE      = 6'h0f;
   localparam logic [5:0]  IDX_QUAL      = 6'h10;
   localparam logic [5:0]  IDX_CODE0     = 6'h11;
   localparam logic [5:0]  IDX_CODE_LAST = 6'h18;
   localparam logic [5:0]  IDX_MODE      = 6'h20;

   // Status and interrupt enable bit positions
   localparam int unsigned FLG_EMPTY     = 0;
   localparam int unsigned FLG_DONE      = 1;
   localparam int unsigned FLG_OVER      = 2;
   localparam int unsigned FLG_UNDER     = 3;
   localparam int unsigned FLG_N         = 4;

   // Control register fields
   localparam int unsigned CTRL_TX_EN    = 7;
   localparam int unsigned CTRL_RX_EN    = 6;
   localparam logic [7:0]  CTRL_MASK     = 8'hc0;

   // Reset values
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [7:0]  IRQ_EN_RST    = 8'h00;
   localparam logic [7:0]  BYTE_RST      = 8'h00;
   localparam logic [7:0]  QUAL_RST      = 8'h00;
   localparam logic [1:0]  MODE_RST      = 2'h0;
   localparam logic [63:0] CODE_RST      = 64'h1e8b6a3de0e9b222;

   // Chips per bit and the bit value sent during an unqualified bit time
   localparam int unsigned CHIPS_FULL    = 64;
   localparam int unsigned CHIPS_HALF    = 32;
   localparam logic        PREAMBLE_BIT  = 1'b1;

   typedef enum logic [1:0] {CM_FULL64, CM_LOW32, CM_HIGH32, CM_DUAL32} txs_code_mode_type;
   typedef enum logic [1:0] {TX_OFF, TX_IDLE, TX_SHIFT} txs_tx_state_type;

endpackage : txs_pkg

`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the transmit serializer
`default_nettype none

module tb_top
   import txs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk = 1'b0;
   logic        nrst    = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        tx_chip_a, tx_chip_b, tx_chip_valid, tx_dual, irq;
   int          err_total = 0;
   int          cmp_count = 0;

   always #50 ref_clk = ~ref_clk;

   txs_host_model txs_host_model_inst (
      .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   txs_tx_serializer txs_tx_serializer_inst (
      .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_chip_a(tx_chip_a),
      .tx_chip_b(tx_chip_b), .tx_chip_valid(tx_chip_valid), .tx_dual(tx_dual),
      .irq(irq));

   task automatic tally_and_finish;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      begin
         cmp_count++;
         if (got !== exp)
         begin
            err_total++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
         end
      end
   endtask : chk

   task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] r;
      logic        e;
      begin
         txs_host_model_inst.xfer(1'b0, idx, 8'h00, r, e);
         chk(r, exp, what);
      end
   endtask : rd

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      begin
         txs_host_model_inst.xfer(1'b1, idx, d, r, e);
      end
   endtask : wr

   // Chips of each bit: code as is for a one, inverted for a zero
   task automatic grab_bits(input logic [7:0] bits, input int nbits);
      logic [63:0] code;
      begin
         code = CODE_RST;
         for (int b = 0; b < nbits; b++)
            for (int c = 0; c < 64; c++)
            begin
               chk({31'h0, tx_chip_a}, {31'h0, code[c] ^ ~bits[b]}, "chip");
               @(posedge ref_clk);
            end
      end
   endtask : grab_bits

   task automatic wait_valid(input logic lvl);
      int n;
      begin
         n = 0;
         while (tx_chip_valid !== lvl && n < 400)
         begin
            @(posedge ref_clk);
            n++;
         end
         if (tx_chip_valid !== lvl)
         begin
            err_total++;
            $display("[FAIL] %0t chip valid never reached %b", $time, lvl);
            tally_and_finish();
         end
      end
   endtask : wait_valid

   // One 32-chip bit time in a half-code mode; off is the code bit of chip A's first chip,
   // a the data bit on channel A, b high when channel B sends a one beside it
   task automatic half_bit(input logic [7:0] m, input logic [7:0] q, input logic [7:0] d,
                           input int off, input logic a, input logic b);
      logic [63:0] code;
      begin
         code = CODE_RST;
         wr(IDX_MODE, m);
         wr(IDX_QUAL, q);
         wr(IDX_BYTE, d);
         wait_valid(1'b1);
         for (int c = 0; c < 32; c++)
         begin
            chk({31'h0, tx_chip_a}, {31'h0, code[off + c] ^ ~a}, "half chip a");
            chk({31'h0, tx_chip_b}, {31'h0, code[32 + c] & b}, "half chip b");
            @(posedge ref_clk);
         end
         wait_valid(1'b0);
      end
   endtask : half_bit

   initial
   begin
      logic [31:0] r;
      logic        e;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
         rd(IDX_CODE0 + 6'(i), {24'h0, CODE_RST[8*i +: 8]}, "code reset");
      rd(IDX_STAT, 32'h0, "status while off");
      txs_host_model_inst.xfer(1'b0, 6'h3f, 8'h00, r, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      chk(r, 32'h0, "unmapped read zero");
      // Mask 0x0d: bit 1 goes out as preamble, byte ends after bit 3
      wr(IDX_QUAL, 8'h0d);
      wr(IDX_BYTE, 8'h58);
      wr(IDX_CTRL, 8'h80);
      rd(IDX_STAT, 32'h0, "no flags before a bit");
      wait_valid(1'b1);
      fork
         grab_bits(8'h0a, 4);
         begin
            rd(IDX_STAT, 32'h1, "empty on load");
            wr(IDX_BYTE, 8'h11);
            rd(IDX_STAT, 32'h0, "empty cleared");
            wr(IDX_BYTE, 8'h22);
            rd(IDX_STAT, 32'h4, "overflow");
         end
      join
      wait_valid(1'b0);
      // Underflow lands one bit time after the end; read before the next one
      repeat (70) @(posedge ref_clk);
      rd(IDX_STAT, 32'hb, "under done empty");
      rd(IDX_STAT, 32'h1, "read clears");
      wr(IDX_STAT, 8'hff);
      rd(IDX_STAT, 32'h1, "status read-only");
      wr(IDX_IRQ_EN, 8'h01);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1, "irq on empty");
      wr(IDX_IRQ_EN, 8'h02);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(IDX_IRQ_EN, 8'h01);
      wr(IDX_MODE, 8'h03);
      @(posedge ref_clk);
      chk({31'h0, tx_dual}, 32'h1, "dual mode");
      half_bit(8'h03, 8'h03, 8'h02, 0, 1'b0, 1'b1);
      half_bit(8'h02, 8'h01, 8'h01, 32, 1'b1, 1'b0);
      wr(IDX_CTRL, 8'h00);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0, "irq when off");
      rd(IDX_STAT, 32'h0, "flags when off");
      tally_and_finish();
   end

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      $display("[FAIL] %0t run did not end in time", $time);
      tally_and_finish();
   end
endmodule : tb_top

`default_nettype wire

//--- verification/txs_host_model.sv
// Host controller model: APB master that drives the serializer's register port
`default_nettype none

module txs_host_model (
   input  wire logic        ref_clk,  // System clock
   output logic             psel,     // APB select
   output logic             penable,  // APB access phase
   output logic             pwrite,   // APB direction
   output logic [7:0]       paddr,    // APB byte address
   output logic [31:0]      pwdata,   // APB write data
   output logic [3:0]       pstrb,    // APB byte strobes
   input  wire logic [31:0] prdata,   // APB read data
   input  wire logic        pready,   // APB ready
   input  wire logic        pslverr   // APB error
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      pstrb   = 4'h0;
   end

   // Only the reset spreading code is ever on air; the host never loads a new one
   // Called just after a rising edge; waits for pready without limit, the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                       output logic [31:0] r, output logic err);
      begin
         psel    <= 1'b1;
         pwrite  <= w;
         paddr   <= {idx, 2'b00};
         pwdata  <= {24'h0, d};
         pstrb   <= 4'hf;
         @(posedge ref_clk);
         penable <= 1'b1;
         do
         begin
            @(posedge ref_clk);
         end
         while (pready !== 1'b1);
         r = prdata;
         err = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge ref_clk);
      end
   endtask : xfer
endmodule : txs_host_model

`default_nettype wire
